//--- src/avc_inverse_transform_mode_indirect_record_unpacker.sv
// Indirect record unpacker for the inverse-transform decode mode,
// with its small input word FIFO.
// Assumes inline data arrive one macroblock at a time from logic on
// the same clock, and indirect words in order: vectors, coefficients,
// then the deblocking control record.
`timescale 1ns/10ps
`include "avc_unpack_regs.svh"

// ********************************************
// Word FIFO
// ********************************************
module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Filling side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// Draining side
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic             push;
	logic             pop;

	// Handshakes; flags are registered so the ports come from flops
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign count_next = count_reg + CW'(push) - CW'(pop);
	assign out_data_o = mem[rd_ptr_reg];

	// Storage; depth must be a power of two for pointer wrap
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	// Pointers, count and flags
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg  <= '0;
			rd_ptr_reg  <= '0;
			count_reg   <= '0;
			in_ready_o  <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			wr_ptr_reg  <= wr_ptr_reg + PW'(push);
			rd_ptr_reg  <= rd_ptr_reg + PW'(pop);
			count_reg   <= count_next;
			in_ready_o  <= count_next != FULL;
			out_valid_o <= count_next != '0;
		end
	end
endmodule // word_fifo

// ********************************************
// Record unpacker
// ********************************************
module avc_inverse_transform_mode_indirect_record_unpacker
	import avc_unpack_pkg::*;
#(
	parameter int CW = 12
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Register port
	input  wire logic [3:0]    addr_i,
	input  wire logic [31:0]   wr_data_i,
	input  wire logic          wr_en_i,
	input  wire logic          rd_en_i,
	output logic      [31:0]   rd_data_o,
	// Indirect word stream
	input  wire logic [31:0]   word_i,
	input  wire logic          word_valid_i,
	output logic               word_ready_o,
	// Inline macroblock information
	input  wire logic          mb_start_i,
	input  wire logic [7:0]    mv_count_field_i,
	input  wire logic [CW-1:0] coef_words_i,
	input  wire avc_unpack_pkg::part_e part_type_i,
	input  wire logic [3:0]    part_pred_i,
	input  wire logic [7:0]    sub_partition_shape_i,
	input  wire logic [7:0]    sub_partition_pred_mode_i,
	output logic               mb_ready_o,
	// Motion vectors
	output logic               mv_valid_o,
	output logic      [15:0]   mv_horz_o,
	output logic      [15:0]   mv_vert_o,
	output logic      [15:0]   chroma_mv_horz_o,
	output logic      [15:0]   chroma_mv_vert_o,
	// Coefficient words
	output logic               coef_valid_o,
	output logic      [31:0]   coef_word_o,
	// Deblocking control
	output logic               dbk_valid_o,
	output logic               filter_top_edge_flag_o,
	output logic               filter_left_edge_flag_o,
	output logic               filter_inner_small_edges_flag_o,
	output logic               filter_inner_large_edges_flag_o,
	output logic               above_field_coded_flag_o,
	output logic               left_field_coded_flag_o,
	output logic               current_field_coded_flag_o,
	output logic               adaptive_frame_field_flag_o,
	output logic      [7:0]    mb_row_position_o,
	output logic      [7:0]    mb_col_position_o,
	output logic      [47:0]   inner_edge_strength_o,
	output logic      [47:0]   boundary_edge_strength_o,
	output logic      [119:0]  filter_threshold_index_a_o,
	output logic      [119:0]  filter_threshold_index_b_o
);
	import avc_unpack_pkg::*;

	// ********************************************
	// Helper functions
	// ********************************************
	// Vectors for one prediction: bi needs one per list
	function automatic logic [5:0] per_pred(input logic [1:0] p);
		per_pred = (p == PRED_BI) ? 6'h02 : 6'h01;
	endfunction

	// Vectors of one 8x8 sub-partition from shape and mode
	function automatic logic [5:0] sub_count(input logic [1:0] s,
	                                         input logic [1:0] p);
		sub_count = per_pred(p) << ((s == 2'h0) ? 1'b0 :
		            (s == 2'h3) ? 2'h2 : 2'h1);
	endfunction

	// Four 4-bit strengths with the unused top bit dropped
	function automatic logic [11:0] drop_msb(input logic [15:0] w);
		drop_msb = {w[14:12], w[10:8], w[6:4], w[2:0]};
	endfunction

	// ********************************************
	// Declarations
	// ********************************************
	logic [31:0]   fifo_data;
	logic          fifo_valid;
	logic          pop;
	state_e        state_reg;
	state_e        state_next;
	logic [7:0]    mv_left_reg;
	logic [CW-1:0] coef_left_reg;
	logic [3:0]    dbk_idx_reg;
	logic [31:0]   dbk_mem [11];
	logic [31:0]   dw [12];
	logic          take_mb;
	logic          dbk_done;
	logic [5:0]    expected;
	logic [5:0]    exp_reg;
	logic [7:0]    given_reg;
	logic          en_reg;
	logic          mism_reg;
	logic          mism_set;
	logic [15:0]   mb_done_reg;
	logic [31:0]   rd_sel;
	logic [239:0]  pairs;

	// ********************************************
	// Input buffer
	// ********************************************
	// Drained only while a macroblock is being parsed, so an idle
	// parser lets the FIFO fill and stalls the fetch path
	word_fifo #(
		.WIDTH       (32),
		.DEPTH       (`FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_data_i   (word_i),
		.in_valid_i  (word_valid_i),
		.in_ready_o  (word_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (state_reg != IDLE_ST)
	);

	assign pop = fifo_valid & (state_reg != IDLE_ST);
	assign take_mb = mb_start_i & mb_ready_o;
	assign dbk_done = pop & (state_reg == DBK_ST) &
	                  (dbk_idx_reg == `DBK_LAST_IDX);

	// ********************************************
	// Expected vector count
	// ********************************************
	// Table check against the supplied count; part 1 uses pred [3:2]
	always_comb begin
		unique case (part_type_i)
			PART_16X16: expected = per_pred(part_pred_i[1:0]);
			PART_16X8,
			PART_8X16:  expected = per_pred(part_pred_i[1:0]) +
			                       per_pred(part_pred_i[3:2]);
			PART_8X8:   expected =
				sub_count(sub_partition_shape_i[1:0],
				          sub_partition_pred_mode_i[1:0]) +
				sub_count(sub_partition_shape_i[3:2],
				          sub_partition_pred_mode_i[3:2]) +
				sub_count(sub_partition_shape_i[5:4],
				          sub_partition_pred_mode_i[5:4]) +
				sub_count(sub_partition_shape_i[7:6],
				          sub_partition_pred_mode_i[7:6]);
		endcase
	end

	// Zero count marks a macroblock with no vectors, never a mismatch
	assign mism_set = take_mb & (mv_count_field_i != 8'h00) &
	                  (mv_count_field_i != {2'h0, expected});

	// ********************************************
	// Record sequencing
	// ********************************************
	// Vectors, then coefficients, then the fixed deblock record
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			IDLE_ST: if (take_mb) begin
				if (mv_count_field_i != 8'h00)
					state_next = MV_ST;
				else if (coef_words_i != '0)
					state_next = COEF_ST;
				else
					state_next = DBK_ST;
			end
			MV_ST: if (pop && mv_left_reg == 8'h01) begin
				state_next = (coef_left_reg != '0) ? COEF_ST : DBK_ST;
			end
			COEF_ST: if (pop && coef_left_reg == CW'(1)) begin
				state_next = DBK_ST;
			end
			DBK_ST: if (dbk_done) begin
				state_next = IDLE_ST;
			end
		endcase
	end

	// State and record counters
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg     <= IDLE_ST;
			mv_left_reg   <= 8'h00;
			coef_left_reg <= '0;
			dbk_idx_reg   <= 4'h0;
		end else begin
			state_reg <= state_next;
			if (take_mb) begin
				mv_left_reg   <= mv_count_field_i;
				coef_left_reg <= coef_words_i;
				dbk_idx_reg   <= 4'h0;
			end else if (pop) begin
				if (state_reg == MV_ST)
					mv_left_reg <= mv_left_reg - 8'h01;
				if (state_reg == COEF_ST)
					coef_left_reg <= coef_left_reg - CW'(1);
				if (state_reg == DBK_ST)
					dbk_idx_reg <= dbk_idx_reg + 4'h1;
			end
		end
	end

	// Accept inline data only when idle and enabled
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			mb_ready_o <= 1'b0;
		else
			mb_ready_o <= (state_next == IDLE_ST) & en_reg & ~take_mb;
	end

	// ********************************************
	// Vector and coefficient output
	// ********************************************
	// Chroma is half resolution, so a quarter luma sample is an
	// eighth chroma sample; halving gives quarter chroma units
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mv_valid_o       <= 1'b0;
			mv_horz_o        <= 16'h0000;
			mv_vert_o        <= 16'h0000;
			chroma_mv_horz_o <= 16'h0000;
			chroma_mv_vert_o <= 16'h0000;
			coef_valid_o     <= 1'b0;
			coef_word_o      <= 32'h0000_0000;
		end else begin
			mv_valid_o   <= pop & (state_reg == MV_ST);
			coef_valid_o <= pop & (state_reg == COEF_ST);
			if (pop && state_reg == MV_ST) begin
				mv_horz_o <= fifo_data[`MV_HORZ_HI:0];
				mv_vert_o <= fifo_data[31:`MV_VERT_LO];
				chroma_mv_horz_o <= {fifo_data[15],
				                     fifo_data[15:1]};
				chroma_mv_vert_o <= {fifo_data[31],
				                     fifo_data[31:17]};
			end
			if (pop && state_reg == COEF_ST)
				coef_word_o <= fifo_data;
		end
	end

	// ********************************************
	// Deblock record capture
	// ********************************************
	// Words 0 to 10 are held; word 11 is decoded straight off the FIFO
	always_ff @(posedge clk_i) begin
		if (pop && state_reg == DBK_ST && dbk_idx_reg != `DBK_LAST_IDX)
			dbk_mem[dbk_idx_reg] <= fifo_data;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 11; gi++) begin : g_dw
			assign dw[gi] = dbk_mem[gi];
		end
	endgenerate
	assign dw[11] = fifo_data;

	// Index pairs: dword 4 high half, then low and high of 5 to 11
	assign pairs = {dw[11], dw[10], dw[9], dw[8], dw[7], dw[6],
	                dw[5], dw[4][31:16]};

	// ********************************************
	// Deblock field output
	// ********************************************
	// Fields change only on the last word, so the filter never
	// sees a half-written record
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dbk_valid_o                     <= 1'b0;
			filter_top_edge_flag_o          <= 1'b0;
			filter_left_edge_flag_o         <= 1'b0;
			filter_inner_small_edges_flag_o <= 1'b0;
			filter_inner_large_edges_flag_o <= 1'b0;
			above_field_coded_flag_o        <= 1'b0;
			left_field_coded_flag_o         <= 1'b0;
			current_field_coded_flag_o      <= 1'b0;
			adaptive_frame_field_flag_o     <= 1'b0;
			mb_row_position_o               <= 8'h00;
			mb_col_position_o               <= 8'h00;
			inner_edge_strength_o           <= '0;
			boundary_edge_strength_o        <= '0;
		end else begin
			dbk_valid_o <= dbk_done;
			if (dbk_done) begin
				filter_top_edge_flag_o <= dw[0][`DB0_TOP_BIT];
				filter_left_edge_flag_o <= dw[0][`DB0_LEFT_BIT];
				filter_inner_small_edges_flag_o <= dw[0][`DB0_IN4_BIT];
				filter_inner_large_edges_flag_o <= dw[0][`DB0_IN8_BIT];
				above_field_coded_flag_o <= dw[0][`DB0_ABOVE_BIT];
				left_field_coded_flag_o <= dw[0][`DB0_LFLD_BIT];
				current_field_coded_flag_o <= dw[0][`DB0_CUR_BIT];
				adaptive_frame_field_flag_o <= dw[0][`DB0_MBAFF_BIT];
				mb_row_position_o <= dw[0][15:`DB0_ROW_LO];
				mb_col_position_o <= dw[0][7:0];
				inner_edge_strength_o <= {dw[2][15:0], dw[1]};
				boundary_edge_strength_o <= {drop_msb(dw[4][15:0]),
				                             drop_msb(dw[3][15:0]),
				                             drop_msb(dw[3][31:16]),
				                             drop_msb(dw[2][31:16])};
			end
		end
	end

	// Split each pair into its A and B byte
	generate
		for (gi = 0; gi < 15; gi++) begin : g_idx
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					filter_threshold_index_a_o[gi*8 +: 8] <= 8'h00;
					filter_threshold_index_b_o[gi*8 +: 8] <= 8'h00;
				end else if (dbk_done) begin
					filter_threshold_index_a_o[gi*8 +: 8] <=
						pairs[gi*16 +: 8];
					filter_threshold_index_b_o[gi*8 +: 8] <=
						pairs[gi*16+8 +: 8];
				end
			end
		end
	endgenerate

	// ********************************************
	// Register port
	// ********************************************
	// Enable, sticky mismatch (write one clears, a new set wins),
	// macroblock counter and the last pair of counts
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_reg      <= `CTRL_RESET;
			mism_reg    <= 1'b0;
			mb_done_reg <= 16'h0000;
			exp_reg     <= 6'h00;
			given_reg   <= 8'h00;
		end else begin
			if (wr_en_i && addr_i == `ADDR_CTRL)
				en_reg <= wr_data_i[`CTRL_EN_BIT];
			if (mism_set)
				mism_reg <= 1'b1;
			else if (wr_en_i && addr_i == `ADDR_STATUS &&
			         wr_data_i[`STAT_MISM_BIT])
				mism_reg <= 1'b0;
			if (dbk_done)
				mb_done_reg <= mb_done_reg + 16'h0001;
			if (take_mb) begin
				exp_reg   <= expected;
				given_reg <= mv_count_field_i;
			end
		end
	end

	// Read selection; unmapped offsets read zero
	assign rd_sel =
		(addr_i == `ADDR_CTRL)    ? {31'h0, en_reg} :
		(addr_i == `ADDR_STATUS)  ? {30'h0, state_reg != IDLE_ST,
		                             mism_reg} :
		(addr_i == `ADDR_MB_DONE) ? {16'h0000, mb_done_reg} :
		(addr_i == `ADDR_COUNTS)  ? {16'h0000, given_reg,
		                             2'h0, exp_reg} :
		32'h0000_0000;

	// Read data stand one cycle after the strobe only
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			rd_data_o <= 32'h0000_0000;
		else
			rd_data_o <= rd_en_i ? rd_sel : 32'h0000_0000;
	end
endmodule // avc_inverse_transform_mode_indirect_record_unpacker

//--- common/avc_unpack_regs.svh
// Offsets, field positions, reset values and counts of the unpacker.
// Assumes byte addresses on a 4-bit register port, 32-bit data.
`ifndef AVC_UNPACK_REGS_SVH
`define AVC_UNPACK_REGS_SVH

// Register offsets
`define ADDR_CTRL      4'h0
`define ADDR_STATUS    4'h4
`define ADDR_MB_DONE   4'h8
`define ADDR_COUNTS    4'hC

// Register fields and reset values
`define CTRL_EN_BIT    0
`define STAT_MISM_BIT  0
`define STAT_BUSY_BIT  1
`define CTRL_RESET     1'b0

// Record layout and FIFO depth
`define DBK_LAST_IDX   4'hB
`define MV_HORZ_HI     15
`define MV_VERT_LO     16
`define DB0_TOP_BIT    23
`define DB0_LEFT_BIT   22
`define DB0_IN4_BIT    21
`define DB0_IN8_BIT    20
`define DB0_ABOVE_BIT  19
`define DB0_LFLD_BIT   18
`define DB0_CUR_BIT    17
`define DB0_MBAFF_BIT  16
`define DB0_ROW_LO     8
`define FIFO_DEPTH     4

`endif

//--- common/avc_unpack_pkg.sv
// Types shared by the indirect record unpacker.
// Assumes nothing of its surroundings.
package avc_unpack_pkg;
	// Macroblock partition of the current macroblock
	typedef enum logic [1:0] {
		PART_16X16,
		PART_16X8,
		PART_8X16,
		PART_8X8
	} part_e;

	// Prediction mode of a part or sub-partition
	typedef enum logic [1:0] {
		PRED_L0,
		PRED_L1,
		PRED_BI,
		PRED_RSV
	} pred_e;

	// Parser states
	typedef enum logic [1:0] {
		IDLE_ST,
		MV_ST,
		COEF_ST,
		DBK_ST
	} state_e;
endpackage

//--- tb/avc_unpack_properties.sv
// Checker of the record unpacker, bound to its top module.
// Assumes one clock and the asynchronous active-high reset.
`timescale 1ns/10ps

// ****************************************
// Unpacker checker
// ****************************************
module avc_unpack_checker #(
	parameter int CW = 12
) (
	// Clock and reset
	input wire logic          clk_i,
	input wire logic          rst_i,
	// Inline side and word stream
	input wire logic          mb_start_i,
	input wire logic [7:0]    mv_count_field_i,
	input wire logic [CW-1:0] coef_words_i,
	input wire logic          mb_ready_o,
	input wire logic          word_valid_i,
	input wire logic          word_ready_o,
	// Unpacked outputs
	input wire logic          mv_valid_o,
	input wire logic [15:0]   mv_horz_o,
	input wire logic [15:0]   mv_vert_o,
	input wire logic [15:0]   chroma_mv_horz_o,
	input wire logic [15:0]   chroma_mv_vert_o,
	input wire logic          dbk_valid_o,
	input wire logic [7:0]    mb_row_position_o,
	input wire logic [7:0]    mb_col_position_o
);
	logic [7:0]    mvq_reg;
	logic [7:0]    mv_seen_reg;
	logic [CW-1:0] coef_q_reg;
	logic [15:0]   total_reg;
	logic [15:0]   used_reg;
	wire           start_taken = mb_start_i && mb_ready_o;
	wire  [15:0]   need = 16'(mvq_reg) + 16'(coef_q_reg) + 16'h000C;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Word totals run across macroblocks, since the buffer prefetches
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mvq_reg     <= 8'h00;
			mv_seen_reg <= 8'h00;
			coef_q_reg  <= '0;
			total_reg   <= 16'h0000;
			used_reg    <= 16'h0000;
		end else begin
			mvq_reg     <= start_taken ? mv_count_field_i : mvq_reg;
			coef_q_reg  <= start_taken ? coef_words_i : coef_q_reg;
			mv_seen_reg <= start_taken ? 8'h00 : mv_seen_reg + 8'(mv_valid_o);
			total_reg   <= total_reg + 16'(word_valid_i && word_ready_o);
			used_reg    <= dbk_valid_o ? used_reg + need : used_reg;
		end
	end

	sequence s_accept;
		mb_start_i && mb_ready_o;
	endsequence
	sequence s_done;
		dbk_valid_o;
	endsequence

	property p_chroma_h;
		mv_valid_o |-> chroma_mv_horz_o == {mv_horz_o[15], mv_horz_o[15:1]};
	endproperty
	a_chroma_h: assert property (p_chroma_h)
		else $error("chroma x not derived from luma");
	property p_chroma_v;
		mv_valid_o |-> chroma_mv_vert_o == {mv_vert_o[15], mv_vert_o[15:1]};
	endproperty
	a_chroma_v: assert property (p_chroma_v)
		else $error("chroma y not derived from luma");
	property p_start_busy;
		s_accept |=> !mb_ready_o;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("ready stayed up after a start");
	property p_mv_busy;
		mv_valid_o |-> !mb_ready_o;
	endproperty
	a_mv_busy: assert property (p_mv_busy)
		else $error("vector seen while idle");
	property p_dbk_pulse;
		s_done |=> !dbk_valid_o;
	endproperty
	a_dbk_pulse: assert property (p_dbk_pulse)
		else $error("deblock valid longer than a cycle");
	property p_dbk_words;
		s_done |-> total_reg >= used_reg + need;
	endproperty
	a_dbk_words: assert property (p_dbk_words)
		else $error("deblock shown before its words arrived");
	property p_mv_total;
		s_done |-> mv_seen_reg == mvq_reg;
	endproperty
	a_mv_total: assert property (p_mv_total)
		else $error("vector pulses differ from count");
	property p_pos_hold;
		!dbk_valid_o |-> $stable({mb_row_position_o, mb_col_position_o});
	endproperty
	a_pos_hold: assert property (p_pos_hold)
		else $error("position moved between records");
endmodule // avc_unpack_checker

bind avc_inverse_transform_mode_indirect_record_unpacker avc_unpack_checker #(.CW(CW))
	u_avc_unpack_checker (.*);

//--- tb/word_source.sv
// Word source standing in for the indirect data fetch path.
// Assumes the bench fills its queue in record order.
`timescale 1ns/10ps

// ****************************************
// Word source
// ****************************************
module word_source (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Handshake with the unpacker
	input  wire logic        ready_i,
	input  wire logic        stall_i,
	output logic             valid_o,
	output logic      [31:0] word_o
);
	logic [31:0] q[$];
	logic        held;

	// An offered word is held until taken; idle bus is scrambled
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			word_o  <= 32'h00000000;
		end else begin
			held = valid_o && !ready_i;
			if (valid_o && ready_i)
				void'(q.pop_front());
			if (q.size() > 0 && (held || !stall_i)) begin
				valid_o <= 1'b1;
				word_o  <= q[0];
			end else begin
				valid_o <= 1'b0;
				word_o  <= ~word_o;
			end
		end
	end
endmodule // word_source

//--- tb/tb_avc_inverse_transform_mode_indirect_record_unpacker.sv
// Self-checking bench of the record unpacker.
// Assumes the word source model and the bound checker.
`timescale 1ns/10ps
`include "avc_unpack_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch at %0t: got %h want %h", $time, g, e); end end

// ****************************************
// Bench top
// ****************************************
module tb_avc_inverse_transform_mode_indirect_record_unpacker;
	import avc_unpack_pkg::*;
	int num_errors = 0;
	int tests_run = 0;
	int mbs = 0;
	logic clk_i = 1'b0, rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
	logic mb_start_i = 1'b0, stall = 1'b0, slow = 1'b0;
	logic [3:0] addr_i = 4'h0, part_pred_i = 4'h0;
	logic [31:0] wr_data_i = 32'h0, rd_data_o, word_i, coef_word_o;
	logic [7:0] mv_count_field_i = 8'h00, sub_partition_shape_i = 8'h00;
	logic [7:0] sub_partition_pred_mode_i = 8'h00;
	logic [11:0] coef_words_i = 12'h000;
	part_e part_type_i = PART_16X16;
	logic word_valid_i, word_ready_o, mb_ready_o, mv_valid_o, coef_valid_o;
	logic dbk_valid_o, filter_top_edge_flag_o, filter_left_edge_flag_o;
	logic filter_inner_small_edges_flag_o, filter_inner_large_edges_flag_o;
	logic above_field_coded_flag_o, left_field_coded_flag_o;
	logic current_field_coded_flag_o, adaptive_frame_field_flag_o;
	logic [15:0] mv_horz_o, mv_vert_o, chroma_mv_horz_o, chroma_mv_vert_o;
	logic [7:0] mb_row_position_o, mb_col_position_o;
	logic [47:0] inner_edge_strength_o, boundary_edge_strength_o;
	logic [119:0] filter_threshold_index_a_o, filter_threshold_index_b_o;
	logic [31:0] mv_q[$], coef_q[$], mv_e, cf_e;
	wire [7:0] flags = {filter_top_edge_flag_o, filter_left_edge_flag_o,
		filter_inner_small_edges_flag_o, filter_inner_large_edges_flag_o,
		above_field_coded_flag_o, left_field_coded_flag_o,
		current_field_coded_flag_o, adaptive_frame_field_flag_o};

	avc_inverse_transform_mode_indirect_record_unpacker #(.CW(12))
		u_avc_inverse_transform_mode_indirect_record_unpacker (.*);
	word_source u_word_source (.clk_i(clk_i), .rst_i(rst_i),
		.ready_i(word_ready_o), .stall_i(stall),
		.valid_o(word_valid_i), .word_o(word_i));

	// Clock, and a far side that stalls every other cycle when slow
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i) stall <= slow & ~stall;

	// Streamed vectors and coefficients against what was sent
	always @(posedge clk_i) begin
		#1;
		if (mv_valid_o === 1'b1) begin
			mv_e = mv_q.pop_front();
			`CHK({mv_vert_o, mv_horz_o}, mv_e)
		end
		if (coef_valid_o === 1'b1) begin
			cf_e = coef_q.pop_front();
			`CHK(coef_word_o, cf_e)
		end
	end

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1 `CHK(rd_data_o, e)
	endtask

	// Bounded wait for idle (0) or for a finished record (1)
	task automatic await(input bit dbk);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge clk_i);
			#1;
			if ((dbk ? dbk_valid_o : mb_ready_o) === 1'b1) break;
		end
		if (n == 400) begin
			num_errors++;
			$display("mismatch at %0t: wait ran out", $time);
			end_sim();
		end
	endtask

	function automatic logic [11:0] d3(input logic [15:0] x);
		return {x[14:12], x[10:8], x[6:4], x[2:0]};
	endfunction

	task automatic run_mb(input part_e p, input logic [3:0] pp,
		input logic [7:0] sh, input logic [7:0] sm, input logic [7:0] cnt,
		input logic [11:0] nc, input logic [7:0] id);
		logic [31:0] dw[12];
		logic [31:0] w;
		logic [239:0] pr;
		logic [119:0] ea, eb;
		for (int k = 0; k < cnt + nc + 12; k++) begin
			w = {id ^ 8'(k * 3), 8'(k * 29 + id), 8'(id * 7 + k), 8'(k * 53)};
			if (k < cnt) mv_q.push_back(w);
			else if (k < cnt + nc) coef_q.push_back(w);
			else dw[k - cnt - nc] = w;
			u_word_source.q.push_back(w);
		end
		await(1'b0);
		@(posedge clk_i);
		{part_type_i, part_pred_i, sub_partition_shape_i} <= {p, pp, sh};
		{sub_partition_pred_mode_i, mv_count_field_i} <= {sm, cnt};
		coef_words_i <= nc;
		mb_start_i <= 1'b1;
		@(posedge clk_i);
		mb_start_i <= 1'b0;
		await(1'b1);
		mbs++;
		pr = {dw[11], dw[10], dw[9], dw[8], dw[7], dw[6], dw[5], dw[4][31:16]};
		for (int k = 0; k < 15; k++) begin
			ea[8*k +: 8] = pr[16*k +: 8];
			eb[8*k +: 8] = pr[16*k+8 +: 8];
		end
		`CHK(flags, dw[0][23:16])
		`CHK({mb_row_position_o, mb_col_position_o}, dw[0][15:0])
		`CHK(inner_edge_strength_o, {dw[2][15:0], dw[1]})
		`CHK(boundary_edge_strength_o, {d3(dw[4][15:0]), d3(dw[3][15:0]),
			d3(dw[3][31:16]), d3(dw[2][31:16])})
		`CHK(filter_threshold_index_a_o, ea)
		`CHK(filter_threshold_index_b_o, eb)
		`CHK(mv_q.size() + coef_q.size(), 0)
	endtask

	// One macroblock whose supplied count matches the expected count
	task automatic cnt_case(input part_e p, input logic [3:0] pp,
		input logic [7:0] sh, input logic [7:0] sm, input logic [5:0] e);
		run_mb(p, pp, sh, sm, {2'b00, e}, 12'(mbs % 3), 8'(mbs * 17));
		rd(`ADDR_COUNTS, {16'h0000, 2'b00, e, 2'b00, e});
		rd(`ADDR_STATUS, 32'h00000000);
		rd(`ADDR_MB_DONE, 32'(mbs));
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`ADDR_CTRL, 32'h00000000);
		rd(`ADDR_STATUS, 32'h00000000);
		rd(4'h2, 32'h00000000);
		`CHK(mb_ready_o, 1'b0)
		// Words pile up in the buffer until the parser is enabled
		fork
			cnt_case(PART_16X16, 4'h0, 8'h00, 8'h00, 6'h01);
		join_none
		repeat (12) @(posedge clk_i);
		#1 `CHK(word_ready_o, 1'b0)
		wr(`ADDR_CTRL, 32'h00000001);
		wait fork;
		rd(`ADDR_CTRL, 32'h00000001);
		cnt_case(PART_16X16, 4'h1, 8'h00, 8'h00, 6'h01);
		cnt_case(PART_16X16, 4'h2, 8'h00, 8'h00, 6'h02);
		cnt_case(PART_16X8, 4'h4, 8'h00, 8'h00, 6'h02);
		cnt_case(PART_8X16, 4'h9, 8'h00, 8'h00, 6'h03);
		cnt_case(PART_16X8, 4'h2, 8'h00, 8'h00, 6'h03);
		cnt_case(PART_8X16, 4'hA, 8'h00, 8'h00, 6'h04);
		cnt_case(PART_8X8, 4'h0, 8'hE4, 8'h40, 6'h09);
		slow <= 1'b1;
		cnt_case(PART_8X8, 4'h0, 8'hFF, 8'hAA, 6'h20);
		cnt_case(PART_8X8, 4'h0, 8'h1B, 8'hAA, 6'h12);
		slow <= 1'b0;
		// Supplied count differs from the shape: flagged, then cleared
		run_mb(PART_16X16, 4'h0, 8'h00, 8'h00, 8'h05, 12'h001, 8'h3C);
		rd(`ADDR_STATUS, 32'h00000001);
		rd(`ADDR_COUNTS, 32'h00000501);
		wr(`ADDR_STATUS, 32'h00000001);
		rd(`ADDR_STATUS, 32'h00000000);
		// No vectors at all is a legal count and raises no flag
		run_mb(PART_16X16, 4'h0, 8'h00, 8'h00, 8'h00, 12'h003, 8'h5A);
		rd(`ADDR_STATUS, 32'h00000000);
		end_sim();
	end
endmodule // tb_avc_inverse_transform_mode_indirect_record_unpacker
